// ==== core/fsh_pkg.sv ====
// Purpose: Shared constants and types for the pump fault state handler.
// Assumes: 10 MHz system clock, APB register access, 32-bit data.
// Notes:   Error table order fixes the bit index of each error flag.
package fsh_pkg;

  localparam int unsigned NUM_ERR = 8;

  typedef enum logic [4:0] {
    FSH_INIT     = 5'b00001,
    FSH_DISABLED = 5'b00010,
    FSH_ACTIVE   = 5'b00100,
    FSH_FAULT    = 5'b01000,
    FSH_HOLD     = 5'b10000
  } fsh_state_e;

  typedef enum logic [1:0] {
    SEV_INFO     = 2'h0,
    SEV_WARNING  = 2'h1,
    SEV_CRITICAL = 2'h2,
    SEV_SEVERE   = 2'h3
  } fsh_sev_e;

  // State codes published to software
  localparam logic [2:0] CODE_INIT     = 3'h0;
  localparam logic [2:0] CODE_DISABLED = 3'h1;
  localparam logic [2:0] CODE_ACTIVE   = 3'h2;
  localparam logic [2:0] CODE_FAULT    = 3'h3;
  localparam logic [2:0] CODE_HOLD     = 3'h4;

  // Error bit indices
  // supply voltage warnings at bits 0 and 1; temperatures, name conflict and coil supply follow
  localparam int unsigned ERR_SUPPLY_HIGH = 0;
  localparam int unsigned ERR_SUPPLY_LOW  = 1;
  localparam int unsigned ERR_CTRL_HOT    = 2;
  localparam int unsigned ERR_CTRL_COLD   = 3;
  localparam int unsigned ERR_PUMP_HOT    = 4;
  localparam int unsigned ERR_PUMP_COLD   = 5;
  localparam int unsigned ERR_NAME_CONF   = 6;
  localparam int unsigned ERR_COIL_SUPPLY = 7;

  localparam logic [18:0] ERR_SPN [NUM_ERR] = '{
    19'h000a8, 19'h000a8, 19'h001b9, 19'h001b9,
    19'h001ba, 19'h001ba, 19'h00b20, 19'h00e0f};
  localparam logic [4:0] ERR_FMI [NUM_ERR] = '{
    5'h03, 5'h04, 5'h10, 5'h11, 5'h10, 5'h11, 5'h1f, 5'h02};
  localparam fsh_sev_e ERR_SEV [NUM_ERR] = '{
    SEV_WARNING, SEV_WARNING, SEV_CRITICAL, SEV_INFO,
    SEV_CRITICAL, SEV_INFO, SEV_SEVERE, SEV_SEVERE};

  // Register byte offsets
  localparam logic [11:0] REG_STATE    = 12'h000;
  localparam logic [11:0] REG_CTRL     = 12'h004;
  localparam logic [11:0] REG_ACTIVE   = 12'h008;
  localparam logic [11:0] REG_PREV     = 12'h00c;
  localparam logic [11:0] REG_ERR_ID   = 12'h010;
  localparam logic [11:0] REG_CNT_BASE = 12'h020;

  // Control register fields
  localparam int unsigned CTRL_IGN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam logic        CTRL_IGN_RST = 1'b0;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned SYNC_W = 3;

  typedef struct packed {
    logic dm11;
    logic dm13;
    logic dm3;
  } fsh_msg_s;

  typedef struct packed {
    fsh_state_e                     state;
    logic                           ign_en;
    logic [NUM_ERR-1:0]             prev;
    logic                           severe_seen;
    logic [NUM_ERR-1:0][CNT_W-1:0]  cnt;
    logic [NUM_ERR-1:0]             act_q;
    logic [NUM_ERR-1:0][SYNC_W-1:0] sync;
    logic [NUM_ERR-1:0]             filt;
    logic [2:0]                     err_sel;
    logic [31:0]                    prdata;
    logic                           acc;
  } fsh_reg_s;

endpackage : fsh_pkg

// ==== core/fsh_handler.sv ====
// Purpose: Fault state handler: classifies errors and runs the state machine.
// Assumes: Error inputs come from pins and are filtered; messages are pulses.
// Notes:   APB slave, one wait state; unmapped reads return zero, pslverr 0.
module fsh_handler
  import fsh_pkg::*;
#(
  parameter logic IGN_RST = CTRL_IGN_RST // Start-up ignore after restart
)
(
  input  wire logic               i_sys_clk,    // 10 MHz clock
  input  wire logic               i_arst_n,     // Async reset, low
  input  wire logic [NUM_ERR-1:0] i_err_raw,    // Raw error conditions
  input  wire fsh_msg_s           i_msg,        // Diagnostic message pulses
  input  wire logic               i_psel,       // APB select
  input  wire logic               i_penable,    // APB enable
  input  wire logic               i_pwrite,     // APB direction
  input  wire logic [11:0]        i_paddr,      // APB address
  input  wire logic [31:0]        i_pwdata,     // APB write data
  output logic      [31:0]        o_prdata,     // APB read data
  output logic                    o_pready,     // APB ready
  output logic                    o_pslverr,    // APB error
  output logic      [2:0]         o_state_code, // Handler state code
  output logic                    o_pump_run,   // Pump allowed to operate
  output logic                    o_net_stop    // Stop network traffic
);

  fsh_reg_s r;
  fsh_reg_s next_r;

  logic               wr_en;
  logic               rd_en;
  logic [NUM_ERR-1:0] sev_mask_warn;
  logic [NUM_ERR-1:0] sev_mask_crit;
  logic [NUM_ERR-1:0] sev_mask_svr;
  logic               any_warn;
  logic               any_hard;
  logic               any_stop;
  logic [NUM_ERR-1:0] reported;
  logic [NUM_ERR-1:0] rise;
  logic               cnt_clr;

  function automatic logic [NUM_ERR-1:0] sev_mask(input fsh_sev_e s);
    logic [NUM_ERR-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_ERR; i++) begin
      m[i] = (ERR_SEV[i] == s);
    end
    return m;
  endfunction

  function automatic logic [2:0] state_code(input fsh_state_e s);
    logic [2:0] c;
    c = CODE_INIT;
    unique case (s)
      FSH_INIT:     c = CODE_INIT;
      FSH_DISABLED: c = CODE_DISABLED;
      FSH_ACTIVE:   c = CODE_ACTIVE;
      FSH_FAULT:    c = CODE_FAULT;
      FSH_HOLD:     c = CODE_HOLD;
      default:      c = CODE_INIT;
    endcase
    return c;
  endfunction

  assign sev_mask_warn = sev_mask(SEV_WARNING);
  assign sev_mask_crit = sev_mask(SEV_CRITICAL);
  assign sev_mask_svr  = sev_mask(SEV_SEVERE);

  // Writes land only at the ready edge, so a one-shot clear fires once
  assign wr_en = i_psel & i_penable & i_pwrite & r.acc;
  assign rd_en = i_psel & i_penable & ~i_pwrite;

  assign any_warn = |(r.filt & sev_mask_warn);
  assign any_hard = |(r.filt & (sev_mask_crit | sev_mask_svr));
  assign any_stop = any_warn | any_hard | r.severe_seen;

  // nothing reported while disabled except critical and severe
  assign reported = (r.state == FSH_DISABLED) ?
                    (r.filt & (sev_mask_crit | sev_mask_svr)) : r.filt;
  assign rise    = reported & ~r.act_q;
  assign cnt_clr = i_msg.dm3 |
                   (wr_en && i_paddr == REG_CTRL && i_pwdata[CTRL_CLR_BIT]);

  always_comb begin
    next_r = r;
    // Read data is registered, so ready waits one access cycle
    next_r.acc = i_psel & i_penable & ~r.acc;
    // Third stage compared with second: the first is never looked at
    for (int i = 0; i < NUM_ERR; i++) begin
      next_r.sync[i] = {r.sync[i][SYNC_W-2:0], i_err_raw[i]};
      if (r.sync[i][1] == r.sync[i][2]) begin
        next_r.filt[i] = r.sync[i][2];
      end
    end
    next_r.act_q = reported;
    next_r.prev = r.prev | (r.act_q & ~reported);
    // occurrence counting, saturating; new rise beats clear unless the count is saturated
    for (int i = 0; i < NUM_ERR; i++) begin
      if (cnt_clr) begin
        next_r.cnt[i] = '0;
      end
      if (rise[i] && r.cnt[i] != '1) begin
        next_r.cnt[i] = cnt_clr ? CNT_W'(1) : r.cnt[i] + CNT_W'(1);
      end
    end
    if (i_msg.dm3) begin
      next_r.prev = r.act_q & ~reported;
    end
    if (|(r.filt & sev_mask_svr)) begin
      next_r.severe_seen = 1'b1;
    end
    unique case (r.state)
      FSH_INIT: begin
        // hold in disabled when option on
        next_r.state = r.ign_en ? FSH_DISABLED : FSH_ACTIVE;
      end
      FSH_DISABLED: begin
        if (any_hard) begin
          next_r.state = FSH_FAULT;
        end else if (i_msg.dm13) begin
          next_r.state = any_stop ? FSH_FAULT : FSH_ACTIVE;
        end
      end
      FSH_ACTIVE: begin
        if (any_stop) begin
          next_r.state = FSH_FAULT;
        end
      end
      FSH_FAULT: begin
        if (!any_stop) begin
          next_r.state = FSH_HOLD;
        end
      end
      FSH_HOLD: begin
        if (any_stop) begin
          next_r.state = FSH_FAULT;
        end else if (i_msg.dm11) begin
          next_r.state = FSH_ACTIVE;
        end
      end
      default: next_r.state = FSH_INIT;
    endcase
    if (wr_en && i_paddr == REG_CTRL) begin
      next_r.ign_en = i_pwdata[CTRL_IGN_BIT];
    end
    if (wr_en && i_paddr == REG_ERR_ID) begin
      next_r.err_sel = i_pwdata[2:0];
    end
    next_r.prdata = '0;
    if (rd_en) begin
      if (i_paddr == REG_STATE) begin
        next_r.prdata = {29'h0, state_code(r.state)};
      end else if (i_paddr == REG_CTRL) begin
        next_r.prdata = {31'h0, r.ign_en};
      end else if (i_paddr == REG_ACTIVE) begin
        next_r.prdata = {24'h0, r.act_q};
      end else if (i_paddr == REG_PREV) begin
        next_r.prdata = {24'h0, r.prev};
      end else if (i_paddr == REG_ERR_ID) begin
        next_r.prdata = {ERR_SEV[r.err_sel], ERR_FMI[r.err_sel],
                         ERR_SPN[r.err_sel], 3'h0, r.err_sel};
      end else if (i_paddr[11:5] == REG_CNT_BASE[11:5]
                   && i_paddr[1:0] == 2'h0) begin
        next_r.prdata = {16'h0, r.cnt[i_paddr[4:2]]};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r        <= '0;
      r.state  <= FSH_INIT;
      r.ign_en <= IGN_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_pready     = r.acc;
  assign o_pslverr    = 1'b0;
  assign o_prdata     = r.prdata;
  assign o_state_code = state_code(r.state);
  assign o_pump_run   = (r.state == FSH_ACTIVE);
  assign o_net_stop   = r.filt[ERR_NAME_CONF];

  // Assertions

  sequence s_clear_msg;
    i_msg.dm11 && r.state == FSH_HOLD && !any_stop;
  endsequence

  hold_to_active_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_clear_msg |=> o_state_code == CODE_ACTIVE)
    else $error("hold did not leave on clear message");

  severe_sticks_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.severe_seen && r.state != FSH_INIT |=>
      o_state_code == CODE_FAULT)
    else $error("severe fault left fault state");

  warn_faults_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.state == FSH_ACTIVE && any_warn |=> r.state == FSH_FAULT)
    else $error("warning did not stop operation");

  disabled_warn_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.state == FSH_DISABLED && !any_hard && !i_msg.dm13 |=>
      r.state == FSH_DISABLED)
    else $error("disabled state left without cause");

  disabled_hard_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.state == FSH_DISABLED && any_hard |=> r.state == FSH_FAULT)
    else $error("hard error ignored while disabled");

  init_skip_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.state == FSH_INIT && !r.ign_en |=> r.state == FSH_ACTIVE)
    else $error("disabled state not skipped");

  no_reenter_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.state != FSH_INIT && r.state != FSH_DISABLED |=>
      r.state != FSH_DISABLED)
    else $error("disabled state entered again");

  pump_state_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    o_pump_run |-> o_state_code == CODE_ACTIVE && !r.severe_seen)
    else $error("pump runs outside active state");

  fault_exit_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.state == FSH_FAULT |=> r.state inside {FSH_FAULT, FSH_HOLD})
    else $error("fault left without clear message");

  count_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_msg.dm3 && rise == '0 |=> r.cnt == '0)
    else $error("counters not cleared");

  net_stop_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    r.filt[ERR_NAME_CONF] |-> o_net_stop ##1 r.severe_seen)
    else $error("name conflict not handled as severe");

endmodule : fsh_handler

// ==== bench/fsh_ctrl_model.sv ====
// Purpose: Far-side system controller model sending diagnostic messages.
// Assumes: Messages are one-cycle pulses launched just after a rising edge.
// Notes:   Only well-formed pulses; the gap lets it answer slowly.
module fsh_ctrl_model
  import fsh_pkg::*;
(
  input  wire logic i_sys_clk, // System clock
  output fsh_msg_s  o_msg      // Message pulses
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_msg = '0;

  task automatic send(input int unsigned kind, input int unsigned gap);
    repeat (gap) @(posedge i_sys_clk);
    o_msg <= fsh_msg_s'(3'b001 << kind);
    @(posedge i_sys_clk);
    o_msg <= '0;
  endtask
endmodule // fsh_ctrl_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the fault state handler.
// Assumes: APB answers after a wait; message bits dm11 2, dm13 1, dm3 0.
// Notes:   A second instance restarts with start-up ignore on (disabled path).
module tb_top;
  import fsh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic         sys_clk = 1'b0;
  // Starts high so the first reset is a real falling edge
  logic         arst_n  = 1'b1;
  logic [7:0]   err_raw = '0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic         pready, pslverr, pump_run, net_stop;
  logic [2:0]   state_code, state_ign;
  logic [31:0]  prdata_ign, rd_ign;
  logic         pump_ign;
  fsh_msg_s     msg;
  int           n_mismatch = 0, num_checks = 0, cycles = 0;
  integer       seed;
  logic [31:0]  r;

  always #50 sys_clk = ~sys_clk;

  fsh_ctrl_model u_ctrl (.i_sys_clk(sys_clk), .o_msg(msg));

  fsh_handler uut (
    .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_err_raw(err_raw),
    .i_msg(msg), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_state_code(state_code),
    .o_pump_run(pump_run), .o_net_stop(net_stop));

  fsh_handler #(.IGN_RST(1'b1)) uut_ign (
    .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_err_raw(err_raw),
    .i_msg(msg), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata_ign),
    .o_pready(), .o_pslverr(), .o_state_code(state_ign),
    .o_pump_run(pump_ign), .o_net_stop());

  localparam logic [18:0] SPN_X [8] = '{19'h000a8, 19'h000a8, 19'h001b9,
    19'h001b9, 19'h001ba, 19'h001ba, 19'h00b20, 19'h00e0f};
  localparam logic [4:0] FMI_X [8] = '{5'h03, 5'h04, 5'h10, 5'h11,
    5'h10, 5'h11, 5'h1f, 5'h02};
  localparam logic [1:0] SEV_X [8] = '{2'h1, 2'h1, 2'h2, 2'h0,
    2'h2, 2'h0, 2'h3, 2'h3};

  function automatic logic [31:0] exp_id(input int i);
    return {SEV_X[i], FMI_X[i], SPN_X[i], 3'h0, 3'(i)};
  endfunction

  function automatic logic [2:0] exp_state(input int i);
    return (SEV_X[i] == 2'h0) ? 3'h2 : 3'h3;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Called just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    rd_ign = prdata_ign;
    chk("pslverr", pslverr, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("reset state", state_code, 3'h0);
    chk("reset pump", pump_run, 0);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("start state", state_code, 3'h2);
    chk("start ign", state_ign, 3'h1);
  endtask

  task automatic test_err(input int i);
    err_raw[i] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("err state", state_code, exp_state(i));
    chk("err pump", pump_run, exp_state(i) == 3'h2);
    apb(1'b0, REG_ACTIVE, '0, rd);
    chk("active bit", rd[i], 1);
    err_raw[i] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    if (SEV_X[i] != 2'h0) begin
      chk("hold state", state_code, 3'h4);
      chk("hold pump", pump_run, 0);
      u_ctrl.send(2, 1);
      repeat (3) @(posedge sys_clk);
    end
    chk("back state", state_code, 3'h2);
    apb(1'b0, REG_PREV, '0, rd);
    chk("prev bit", rd[i], 1);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    seed = 32'h516c5c2b;
    do_reset();
    apb(1'b0, REG_CTRL, '0, rd);
    chk("ctrl reset", rd, 0);
    chk("ctrl ign reset", rd_ign, 1);
    apb(1'b0, 12'h0f0, '0, rd);
    chk("unmapped", rd, 0);
    $display("test reset done");
    // Warning held off while disabled, then ignore-end with it present
    err_raw[0] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("ign warn", state_ign, 3'h1);
    chk("ign pump", pump_ign, 0);
    apb(1'b0, REG_ACTIVE, '0, rd);
    chk("ign report", rd_ign[0], 0);
    u_ctrl.send(1, 1);
    repeat (3) @(posedge sys_clk);
    chk("ign end err", state_ign, 3'h3);
    err_raw[0] <= 1'b0;
    do_reset();
    u_ctrl.send(1, 1);
    repeat (3) @(posedge sys_clk);
    chk("ign end ok", state_ign, 3'h2);
    do_reset();
    err_raw[2] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("ign crit", state_ign, 3'h3);
    err_raw[2] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    u_ctrl.send(2, 1);
    repeat (3) @(posedge sys_clk);
    chk("ign no return", state_ign, 3'h2);
    do_reset();
    $display("test disabled done");
    for (int i = 0; i < 6; i++) test_err(i);
    $display("test severities done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, REG_ERR_ID, 32'(i), rd);
      apb(1'b0, REG_ERR_ID, '0, rd);
      chk("error id", rd, exp_id(i));
      apb(1'b0, REG_CNT_BASE + 12'(4 * i), '0, rd);
      chk("count", rd, (i < 6) ? 1 : 0);
    end
    apb(1'b1, REG_CTRL, 32'h2, rd);
    apb(1'b0, REG_CNT_BASE, '0, rd);
    chk("count clear", rd, 0);
    err_raw[5] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    err_raw[5] <= 1'b0;
    apb(1'b0, REG_CNT_BASE + 12'h014, '0, rd);
    chk("count again", rd, 1);
    u_ctrl.send(0, 2);
    apb(1'b0, REG_CNT_BASE + 12'h014, '0, rd);
    chk("count dm3", rd, 0);
    $display("test counters done");
    for (int k = 0; k < 20; k++) begin
      r = $random(seed);
      err_raw <= 8'({r[1], 1'b0, r[0]} << 3);
      apb(1'b1, REG_ERR_ID, {29'h0, r[4:2]}, rd);
      apb(1'b0, REG_ERR_ID, '0, rd);
      chk("rand id", rd, exp_id(int'(r[4:2])));
      repeat (4) @(posedge sys_clk);
      chk("info state", state_code, 3'h2);
      chk("info pump", pump_run, 1);
    end
    err_raw <= '0;
    $display("test random info done");
    for (int i = 6; i < 8; i++) begin
      err_raw[i] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("severe state", state_code, 3'h3);
      chk("net stop", net_stop, i == 6);
      err_raw[i] <= 1'b0;
      repeat (8) @(posedge sys_clk);
      u_ctrl.send(2, 1);
      repeat (3) @(posedge sys_clk);
      chk("severe kept", state_code, 3'h3);
      chk("severe pump", pump_run, 0);
      do_reset();
    end
    $display("test severe done");
    close_out();
  end
endmodule // tb_top
